// File: hdl/fcp_pkg.sv
// Shared constants and types for the fast control input port, both ends.
// Assumes a 200 MHz system clock on each end and a sampled link clock.
package fcp_pkg;

  // ****************************************
  // Port geometry
  // ****************************************
  localparam int DATA_W = 16;

  // ****************************************
  // Reference pattern
  // ****************************************
  localparam logic [15:0] SEED_I = 16'h306c;
  localparam logic [15:0] SEED_Q = 16'hffff;
  localparam int SHIFT_A = 7;
  localparam int SHIFT_B = 9;
  localparam int SHIFT_C = 8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  // Valid window length in milliseconds: low and high sides of the range, and the nominal length used.
  localparam int WIN_MIN_MS = 2300;
  localparam int WIN_MAX_MS = 3500;
  localparam int WIN_NOM_MS = 2800;
  localparam int WIN_CYC = WIN_NOM_MS * 1000 * CLK_MHZ;
  localparam int CAL_EDGES = 200;
  // Segment mode spacing between valid transitions, in nanoseconds.
  localparam int SEG_SPACE_NS = 4;
  localparam int SEG_SPACE_CYC =
    (SEG_SPACE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
    (SEG_SPACE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] DIV_HALF = 8'h02;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_IQ,
    MODE_SEG
  } port_mode_t;

  typedef enum logic [1:0] {
    RATE_SLOW,
    RATE_FAST
  } rate_t;

  // One step of the xorshift reference generator.
  function automatic logic [15:0] pat_step(input logic [15:0] w);
    logic [15:0] t;
    t = w ^ 16'(w << SHIFT_A);
    t = t ^ (t >> SHIFT_B);
    t = t ^ 16'(t << SHIFT_C);
    return t;
  endfunction

endpackage

// File: hdl/fcp_link_if.sv
// Wires of the eighteen-line port between sender and receiver.
// Assumes both ends sit on the same system clock in the bench.
`timescale 1ns/1ps
`default_nettype none
interface fcp_link_if;
  logic link_clk; // Link clock line.
  logic link_valid; // Valid qualifier line.
  logic [15:0] link_data; // Data lines.

  // The sender drives every line.
  modport sender (
    output link_clk,
    output link_valid,
    output link_data
  );

  // The receiver only samples.
  modport receiver (
    input link_clk,
    input link_valid,
    input link_data
  );
endinterface
`default_nettype wire

// File: hdl/fcp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock domain; width and depth set by parameters.
`timescale 1ns/1ps
`default_nettype none
module fcp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // ****************************************
  // Storage and pointers
  // ****************************************
  logic [WIDTH-1:0] mem [DEPTH]; // Word storage.
  logic [AW:0] wr_r; // Write pointer with wrap bit.
  logic [AW:0] rd_r; // Read pointer with wrap bit.
  logic do_wr;
  logic do_rd;

  // Full when pointers differ only in the wrap bit.
  assign in_ready = !((wr_r[AW] != rd_r[AW]) &&
                      (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign out_valid = (wr_r != rd_r);
  assign out_data = mem[rd_r[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // Pointers move on accepted transfers only.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (do_wr) begin
        wr_r <= wr_r + 1'b1;
      end
      if (do_rd) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end

  // Storage has no reset; only written words are ever read.
  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: hdl/fcp_receiver.sv
// Receiver end of the fast control input port: calibration and segment IDs.
// Assumes link lines arrive asynchronously and are sampled on mclk.
//
// Rules of the port, from the document
// - Sender keeps valid low during setup.
// - Sender clock 250 or 500 MHz; the sender here divides mclk down to 50 MHz.
// - Pattern seeds 306C and FFFF.
// - Xorshift step: left 7, right 9, left 8.
// - Slow rate: I, Q alternate per edge.
// - Valid rise aligns with an I word.
// - Fast rate: each pair sent twice.
// - Data ignored while valid low.
// - Valid windows last 2.3 to 3.5 s.
// - Calibration ends after 200 valid windows.
// - Start command with argument zero begins it.
// - Recalibrate on rate change or use fast.
// - IQ mode and rate set before start.
// - Tune a delay per data line.
// - IQ mode captures on rising link clock.
// - Segment mode only when others off.
// - Segment mode takes 16-bit ID.
// - Latch ID on valid rise, forward it.
// - Sender holds valid low during segment setup.
// - ID changes together with valid edge.
// - Sampled at 250 Mb/s, 4 ns spacing; here sampled on the 200 MHz mclk, segment valid edges 3 cycles apart.
`timescale 1ns/1ps
`default_nettype none
module fcp_receiver
  import fcp_pkg::*;
#(
  parameter int EDGES = CAL_EDGES,
  parameter int TAPS = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  fcp_link_if.receiver link,
  input wire logic iq_stream_mode_command,
  input wire logic segment_mode_command,
  input wire fcp_pkg::rate_t playback_rate_command,
  input wire logic calibration_start_command,
  input wire logic [7:0] calibration_argument,
  output logic [15:0] segment_id,
  output logic segment_id_strobe,
  output logic [15:0] iq_word,
  output logic iq_word_valid,
  output logic calibration_busy,
  output logic calibration_done,
  output logic segment_mode_active,
  output logic iq_mode_active,
  output logic [15:0][1:0] line_delay
);

  localparam int TW = $clog2(TAPS);

  // ****************************************
  // State record
  // ****************************************
  typedef enum {
    ST_IDLE,
    ST_RUN,
    ST_DONE
  } cal_st_t;

  typedef struct packed {
    logic [2:0] clk_s; // Clock synchroniser plus history.
    logic [2:0] val_s; // Valid synchroniser plus history.
    logic [15:0] d1; // Data first stage.
    logic [15:0] d2; // Data second stage.
    port_mode_t mode;
    cal_st_t st;
    logic [15:0] pi; // Local in-phase generator.
    logic [15:0] pq; // Local quadrature generator.
    logic phase_q; // Next word expected is quadrature.
    logic rep; // Second copy of the pair at fast rate.
    logic [7:0] edges; // Valid windows seen.
    logic [15:0][TW-1:0] tap; // Tap under test per line.
    logic [15:0] err; // Mismatch seen in the window.
    logic [15:0][TW-1:0] best; // Chosen delay per line.
    logic [15:0] found; // Line has a clean tap.
    logic armed; // A valid rise has been seen since the start command.
    logic [15:0] seg;
    logic seg_stb;
    logic [15:0] iq;
    logic iq_v;
  } rx_t;

  rx_t s_r;
  rx_t s_nxt;
  logic clk_rise;
  logic val_rise;
  logic val_fall;
  logic val_now;
  logic [15:0] exp_w;
  logic [15:0] g_i; // In-phase generator as used this cycle.
  logic [15:0] g_q; // Quadrature generator as used this cycle.
  logic g_ph; // Word phase as used this cycle.
  logic g_rep; // Repeat flag as used this cycle.
  logic [15:0] g_err; // Window error bits as used this cycle.
  logic fifo_ready;
  logic fifo_ovalid;
  logic [15:0] fifo_odata;

  // Only stages one onward are looked at by edge logic.
  assign clk_rise = s_r.clk_s[1] && !s_r.clk_s[2];
  assign val_rise = s_r.val_s[1] && !s_r.val_s[2];
  assign val_fall = !s_r.val_s[1] && s_r.val_s[2];
  assign val_now = s_r.val_s[1];
  // A valid rise restarts the generator before the word under it is
  // compared, since that word is already the first in-phase word.
  assign g_i = val_rise ? SEED_I : s_r.pi;
  assign g_q = val_rise ? SEED_Q : s_r.pq;
  assign g_ph = val_rise ? 1'b0 : s_r.phase_q;
  assign g_rep = val_rise ? 1'b0 : s_r.rep;
  assign g_err = val_rise ? 16'h0000 : s_r.err;
  assign exp_w = g_ph ? g_q : g_i;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.clk_s = {s_r.clk_s[1:0], link.link_clk};
    s_nxt.val_s = {s_r.val_s[1:0], link.link_valid};
    s_nxt.d1 = link.link_data;
    s_nxt.d2 = s_r.d1;
    s_nxt.seg_stb = 1'b0;
    s_nxt.iq_v = 1'b0;

    // Only one mode may be entered, and only from the idle mode.
    case (s_r.mode)
      MODE_OFF: begin
        if (iq_stream_mode_command && !segment_mode_command) begin
          s_nxt.mode = MODE_IQ;
        end else if (segment_mode_command && !iq_stream_mode_command) begin
          s_nxt.mode = MODE_SEG;
        end
      end
      MODE_IQ: begin
        if (!iq_stream_mode_command && s_r.st != ST_RUN) begin
          s_nxt.mode = MODE_OFF;
        end
      end
      MODE_SEG: begin
        if (!segment_mode_command) begin
          s_nxt.mode = MODE_OFF;
        end
      end
      default: begin
        s_nxt.mode = MODE_OFF;
      end
    endcase

    // Segment IDs are latched once per valid rise.
    if (s_r.mode == MODE_SEG && val_rise) begin
      s_nxt.seg = s_r.d2;
      s_nxt.seg_stb = 1'b1;
    end

    // IQ capture on each sampled rise of the link clock while valid is high.
    if (s_r.mode == MODE_IQ && clk_rise && val_now) begin
      s_nxt.iq = s_r.d2;
      s_nxt.iq_v = fifo_ready;
    end

    // Calibration sequence.
    case (s_r.st)
      ST_IDLE: begin
        if (calibration_start_command && calibration_argument == 8'h00 &&
            s_r.mode == MODE_IQ) begin
          s_nxt.st = ST_RUN;
          s_nxt.edges = '0;
          s_nxt.tap = '0;
          s_nxt.err = '0;
          s_nxt.found = '0;
          s_nxt.armed = 1'b0;
          // A line that never comes clean is left at the longest delay.
          s_nxt.best = '1;
        end
      end
      ST_RUN: begin
        // Keep the generator in step with the sender.
        s_nxt.pi = g_i;
        s_nxt.pq = g_q;
        s_nxt.phase_q = g_ph;
        s_nxt.rep = g_rep;
        s_nxt.err = g_err;
        if (val_rise) begin
          s_nxt.armed = 1'b1;
        end
        if (val_now && clk_rise) begin
          // Compare each line; mismatches only count while valid.
          s_nxt.err = g_err | (s_r.d2 ^ exp_w);
          s_nxt.phase_q = !g_ph;
          if (g_ph) begin
            if (playback_rate_command == RATE_FAST && !g_rep) begin
              s_nxt.rep = 1'b1;
            end else begin
              s_nxt.rep = 1'b0;
              s_nxt.pi = pat_step(g_i);
              s_nxt.pq = pat_step(g_q);
            end
          end
        end
        // A window cut by the start command is never scored.
        if (val_fall && s_r.armed) begin
          // Score the window, then advance every line's tap.
          for (int b = 0; b < 16; b++) begin
            if (!s_r.err[b] && !s_r.found[b]) begin
              s_nxt.best[b] = s_r.tap[b];
              s_nxt.found[b] = 1'b1;
            end
            s_nxt.tap[b] = s_r.tap[b] + 1'b1;
          end
          s_nxt.edges = s_r.edges + 8'h01;
          if (32'(s_r.edges) + 1 >= EDGES) begin
            s_nxt.st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (!calibration_start_command) begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.mode <= MODE_OFF;
      s_r.st <= ST_IDLE;
      s_r.pi <= SEED_I;
      s_r.pq <= SEED_Q;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Captured IQ words queue here; the read side is always ready, and a full FIFO drops new words.
  fcp_fifo #(.WIDTH(16), .DEPTH(16)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(s_r.iq_v),
    .in_ready(fifo_ready),
    .in_data(s_r.iq),
    .out_valid(fifo_ovalid),
    .out_ready(1'b1),
    .out_data(fifo_odata)
  );

  assign segment_id = s_r.seg;
  assign segment_id_strobe = s_r.seg_stb;
  assign iq_word = fifo_odata;
  assign iq_word_valid = fifo_ovalid;
  assign calibration_busy = (s_r.st == ST_RUN);
  assign calibration_done = (s_r.st == ST_DONE);
  assign segment_mode_active = (s_r.mode == MODE_SEG);
  assign iq_mode_active = (s_r.mode == MODE_IQ);

  // Delay codes are cast to two bits each.
  for (genvar g = 0; g < 16; g++) begin : g_dly
    assign line_delay[g] = 2'(s_r.best[g]);
  end
endmodule
`default_nettype wire

// File: hdl/fcp_sender.sv
// Sender end of the port: calibration pattern and segment ID source.
// Assumes the same mclk as the receiver; link clock made by a divider.
`timescale 1ns/1ps
`default_nettype none
module fcp_sender
  import fcp_pkg::*;
#(
  parameter int WIN = WIN_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  fcp_link_if.sender link,
  input wire logic cal_enable,
  input wire fcp_pkg::rate_t rate,
  input wire logic seg_send,
  input wire logic [15:0] seg_value,
  output logic seg_ready
);

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    logic [7:0] div; // Link clock divider.
    logic clk; // Link clock level.
    logic valid;
    logic [15:0] data;
    logic [31:0] win; // Window cycle count.
    logic [15:0] pi;
    logic [15:0] pq;
    logic phase_q;
    logic rep;
    logic [7:0] gap; // Segment spacing count.
  } tx_t;

  tx_t s_r;
  tx_t s_nxt;

  // Valid stays low until calibration or segment traffic.
  always_comb begin
    s_nxt = s_r;
    s_nxt.div = s_r.div + 8'h01;
    if (s_r.div + 8'h01 >= DIV_HALF) begin
      s_nxt.div = '0;
      s_nxt.clk = !s_r.clk;
    end
    if (s_r.gap != 8'h00) begin
      s_nxt.gap = s_r.gap - 8'h01;
    end
    if (cal_enable) begin
      // The window count waits at its end for a link clock rise, so that
      // valid and the first in-phase word always meet a sampling edge.
      if (32'(s_r.win) + 1 < WIN) begin
        s_nxt.win = s_r.win + 32'h0000_0001;
      end
      if (s_nxt.clk && !s_r.clk && 32'(s_r.win) + 1 >= WIN) begin
        s_nxt.win = '0;
        s_nxt.valid = !s_r.valid;
        if (!s_r.valid) begin
          s_nxt.pi = SEED_I;
          s_nxt.pq = SEED_Q;
          s_nxt.data = SEED_I;
          s_nxt.phase_q = 1'b1;
          s_nxt.rep = 1'b0;
        end
      end else if (s_r.valid && s_nxt.clk && !s_r.clk) begin
        // New word in the same cycle as each link clock rise.
        if (s_r.phase_q) begin
          s_nxt.data = s_r.pq;
          s_nxt.phase_q = 1'b0;
        end else begin
          if (rate == RATE_FAST && !s_r.rep) begin
            s_nxt.rep = 1'b1;
            s_nxt.data = s_r.pi;
          end else begin
            s_nxt.rep = 1'b0;
            s_nxt.pi = pat_step(s_r.pi);
            s_nxt.pq = pat_step(s_r.pq);
            s_nxt.data = pat_step(s_r.pi);
          end
          s_nxt.phase_q = 1'b1;
        end
      end
    end else if (seg_send && s_r.gap == 8'h00) begin
      // ID and valid rise together, spaced apart.
      s_nxt.valid = !s_r.valid;
      if (!s_r.valid) begin
        s_nxt.data = seg_value;
      end
      s_nxt.gap = 8'(SEG_SPACE_CYC * 2);
    end
  end

  // State register.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.pi <= SEED_I;
      s_r.pq <= SEED_Q;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.link_clk = s_r.clk;
  assign link.link_valid = s_r.valid;
  assign link.link_data = s_r.data;
  assign seg_ready = !cal_enable && s_r.gap == 8'h00;
endmodule
`default_nettype wire

// File: test/fcp_link_asserts.sv
// Checker for the link lines and the receiver's segment outputs.
// Assumes a single mclk domain; the bench instantiates it beside the link.
`timescale 1ns/1ps
`default_nettype none
module fcp_link_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic link_valid,
  input wire logic [15:0] link_data,
  input wire logic [15:0] segment_id,
  input wire logic segment_id_strobe,
  input wire logic segment_mode_active,
  input wire logic iq_mode_active,
  input wire logic calibration_busy
);
  // ****************************************
  // Clocking and sequences
  // ****************************************
  // One domain, so one clock and one reset serve every check.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // A new identifier edge on the link while segment mode is on.
  sequence seg_rise;
    $rose(link_valid) && segment_mode_active;
  endsequence

  // The receiver's single strobe after its synchroniser delay.
  sequence seg_answer;
    ##[3:4] segment_id_strobe;
  endsequence

  // ****************************************
  // Checks
  // ****************************************
  // Valid never falls on the edge right after a rise, which keeps 4 ns spacing.
  valid_spacing_a: assert property ($rose(link_valid) |=> $stable(link_valid))
    else $error("valid toggled on consecutive cycles");
  // The divided link clock holds each level for at least two cycles.
  link_clk_half_a: assert property ($changed(link_clk) |=> $stable(link_clk))
    else $error("link clock half period too short");
  seg_latency_a: assert property (seg_rise |-> seg_answer)
    else $error("no strobe after valid rise");
  seg_data_a: assert property (segment_id_strobe |->
    segment_id == $past(link_data, 3) || segment_id == $past(link_data, 4))
    else $error("segment id differs from link data");
  strobe_single_a: assert property (segment_id_strobe |=> !segment_id_strobe)
    else $error("strobe longer than one cycle");
  strobe_cause_a: assert property (segment_id_strobe |-> $past(link_valid, 3))
    else $error("strobe without a valid rise");
  id_hold_a: assert property ($changed(segment_id) |-> segment_id_strobe)
    else $error("segment id changed without strobe");
  strobe_mode_a: assert property (segment_id_strobe |-> segment_mode_active)
    else $error("strobe outside segment mode");
  mode_excl_a: assert property
    (!(segment_mode_active && (iq_mode_active || calibration_busy)))
    else $error("segment mode shares the port");
endmodule
`default_nettype wire

// File: test/fast_port_calibration_segment_rx_tb.sv
// Bench: sender and receiver joined over the link, checked at both sides.
// Assumes short windows and edge counts so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module fast_port_calibration_segment_rx_tb;
  import fcp_pkg::*;
  // Three windows are enough to finish a calibration in simulation.
  localparam int EDG = 3;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic iq_cmd = 1'b0, seg_cmd = 1'b0, start = 1'b0;
  logic cal_en = 1'b0, seg_send = 1'b0;
  rate_t rate = RATE_SLOW;
  logic [7:0] arg = 8'h00;
  logic [15:0] seg_value = 16'h0000;
  logic [15:0] segment_id;
  logic [15:0] iq_word;
  logic [15:0] iq_first = 16'h0000;
  logic [15:0][1:0] line_dly;
  logic iq_arm = 1'b0;
  logic strb, iq_valid, busy, done, seg_act, iq_act, seg_ready;
  int err_count = 0, n_tests = 0, rises = 0, strobes = 0, words = 0;
  int cap = 4;
  logic lc_q = 1'b0, vq = 1'b0, vm = 1'b0;
  logic [15:0] w [4];

  fcp_link_if link ();
  fcp_receiver #(.EDGES(EDG), .TAPS(4)) i_fcp_receiver (.mclk(mclk),
    .sys_rst(sys_rst), .link(link.receiver), .iq_stream_mode_command(iq_cmd),
    .segment_mode_command(seg_cmd), .playback_rate_command(rate),
    .calibration_start_command(start), .calibration_argument(arg),
    .segment_id(segment_id), .segment_id_strobe(strb), .iq_word(iq_word),
    .iq_word_valid(iq_valid), .calibration_busy(busy),
    .calibration_done(done), .segment_mode_active(seg_act),
    .iq_mode_active(iq_act), .line_delay(line_dly));
  fcp_sender #(.WIN(64)) i_fcp_sender (.mclk(mclk), .sys_rst(sys_rst),
    .link(link.sender), .cal_enable(cal_en), .rate(rate),
    .seg_send(seg_send), .seg_value(seg_value), .seg_ready(seg_ready));
  fcp_link_asserts i_fcp_link_asserts (.mclk(mclk), .sys_rst(sys_rst),
    .link_clk(link.link_clk), .link_valid(link.link_valid),
    .link_data(link.link_data), .segment_id(segment_id),
    .segment_id_strobe(strb), .segment_mode_active(seg_act),
    .iq_mode_active(iq_act), .calibration_busy(busy));

  // ****************************************
  // Clock and monitor
  // ****************************************
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // Counts events and keeps the first four words after each valid rise.
  always @(posedge mclk) begin
    if (strb === 1'b1) strobes++;
    // The first IQ word after each valid rise is kept for comparison.
    if (iq_valid === 1'b1) begin
      words++;
      if (iq_arm) iq_first = iq_word;
      iq_arm = 1'b0;
    end
    vm <= link.link_valid;
    if (link.link_valid === 1'b1 && vm === 1'b0) begin
      rises++;
      iq_arm = 1'b1;
    end
    lc_q <= link.link_clk;
    if (link.link_clk === 1'b1 && lc_q === 1'b0) begin
      if (link.link_valid === 1'b1 && vq === 1'b0) begin
        w[0] = link.link_data;
        cap = 1;
      end else if (cap < 4) begin
        w[cap] = link.link_data;
        cap++;
      end
      vq <= link.link_valid;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Own copy of the reference step, kept apart from the design's.
  function automatic logic [15:0] stp(input logic [15:0] v);
    logic [15:0] t;
    t = v ^ (v << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction

  task automatic set_modes(input logic iq, input logic seg);
    @(posedge mclk);
    iq_cmd <= iq;
    seg_cmd <= seg;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  // One send; a rise of valid must bring exactly one strobe, if allowed.
  task automatic seg_one(input logic [15:0] v, input logic ok_mode);
    int r;
    int s;
    logic ok;
    r = rises;
    s = strobes;
    @(posedge mclk);
    seg_send <= 1'b1;
    seg_value <= v;
    do begin
      @(negedge mclk);
      ok = seg_ready;
      @(posedge mclk);
    end while (ok !== 1'b1);
    seg_send <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    if (rises != r && ok_mode) begin
      check(segment_id, v);
      check(link.link_data, v);
      check(16'(strobes - s), 16'h0001);
    end else begin
      check(16'(strobes - s), 16'h0000);
    end
  endtask

  // Words after a valid rise: I of some step, its Q, then repeat or next.
  task automatic check_pattern(input logic fast);
    logic [15:0] i;
    logic [15:0] q;
    int n;
    i = SEED_I;
    q = SEED_Q;
    for (n = 0; n < 20000 && i !== w[0]; n++) begin
      i = stp(i);
      q = stp(q);
    end
    check(w[0], i);
    check(w[1], q);
    if (!fast) begin
      i = stp(i);
      q = stp(q);
    end
    check(w[2], i);
    check(w[3], q);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    check(link.link_valid, 1'b0);
    check({busy, done, seg_act, iq_act, strb}, 16'h0000);
  endtask

  // Each identifier is sent twice so a valid rise always carries it.
  task automatic t_segment;
    logic [15:0] ids [5] = '{16'h0000, 16'hffff, 16'ha5a5, 16'h5a5a,
      16'h0001};
    set_modes(1'b0, 1'b1);
    check(seg_act, 1'b1);
    foreach (ids[k]) begin
      seg_one(ids[k], 1'b1);
      seg_one(ids[k], 1'b1);
    end
    set_modes(1'b1, 1'b1);
    check(iq_act, 1'b0);
    @(posedge mclk);
    start <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    check(busy, 1'b0);
    @(posedge mclk);
    start <= 1'b0;
    set_modes(1'b0, 1'b0);
  endtask

  // Segment traffic while IQ mode holds the port must be ignored.
  task automatic t_iq_refuse;
    set_modes(1'b1, 1'b0);
    check(iq_act, 1'b1);
    set_modes(1'b1, 1'b1);
    check(seg_act, 1'b0);
    seg_one(16'h1234, 1'b0);
    seg_one(16'h1234, 1'b0);
    set_modes(1'b1, 1'b0);
  endtask

  // A bad argument is refused; argument zero runs to done.
  task automatic t_cal(input rate_t r);
    int r0;
    int k;
    @(posedge mclk);
    rate <= r;
    cal_en <= 1'b1;
    start <= 1'b1;
    arg <= 8'h01;
    repeat (20) @(posedge mclk);
    #1;
    check(busy, 1'b0);
    @(posedge mclk);
    start <= 1'b0;
    arg <= 8'h00;
    @(posedge mclk);
    r0 = rises;
    words = 0;
    start <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    check(busy, 1'b1);
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge mclk);
    #1;
    check(done, 1'b1);
    check(16'(rises - r0 >= EDG), 16'h0001);
    check(16'(words > 0), 16'h0001);
    check(iq_first, SEED_I);
    check(line_dly[15:8], 16'h0000);
    check(line_dly[7:0], 16'h0000);
    repeat (16) @(posedge mclk);
    check_pattern(r == RATE_FAST);
    start <= 1'b0;
    cal_en <= 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    check(done, 1'b0);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    t_reset();
    t_segment();
    t_iq_refuse();
    t_cal(RATE_SLOW);
    t_cal(RATE_FAST);
    results();
  end

  // Whole run needs well under this; a hang ends as a failure.
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    results();
  end
endmodule
`default_nettype wire
